// >>> core/acmp_cfg.svh
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH

// register byte offsets on the apb bus
`define ACMP_OFF_SETUP1      12'h000
`define ACMP_OFF_SETUP2      12'h004
`define ACMP_OFF_STATUS      12'h008

// setup register field positions
`define ACMP_BIT_ENABLE      15
`define ACMP_BIT_PIN_DRIVE   14
`define ACMP_BIT_INVERT      13
`define ACMP_BIT_LOW_POWER   12
`define ACMP_BIT_EVENT       9
`define ACMP_BIT_RESULT      8
`define ACMP_BIT_EDGE_HI     7
`define ACMP_BIT_EDGE_LO     6
`define ACMP_BIT_POS_SEL     4
`define ACMP_BIT_NEG_HI      1
`define ACMP_BIT_NEG_LO      0

// shared status register field positions
`define ACMP_BIT_IDLE_HALT   15
`define ACMP_BIT_EVT_MIRROR  8
`define ACMP_BIT_RES_MIRROR  0

// every implemented bit resets to zero
`define ACMP_SETUP_RESET     16'h0000
`define ACMP_STATUS_RESET    16'h0000

`endif

// >>> core/acmp_pkg.sv
package acmp_pkg;

	// event edge select encodings
	typedef enum logic [1:0] {
		ACMP_EDGE_OFF  = 2'h0,
		ACMP_EDGE_RISE = 2'h1,
		ACMP_EDGE_FALL = 2'h2,
		ACMP_EDGE_ANY  = 2'h3
	} acmp_edge_t;

	// negative input route encodings
	typedef enum logic [1:0] {
		ACMP_NEG_PIN2 = 2'h0,
		ACMP_NEG_PIN3 = 2'h1,
		ACMP_NEG_PIN4 = 2'h2,
		ACMP_NEG_BGAP = 2'h3
	} acmp_neg_t;

	// per-comparator edge-tracker state, gray along the arm path
	typedef enum logic [1:0] {
		ACMP_ST_IDLE  = 2'b00,
		ACMP_ST_FIRST = 2'b01,
		ACMP_ST_ARMED = 2'b11
	} acmp_state_t;

	// software-written setup fields of one comparator
	typedef struct packed {
		logic       enable;
		logic       pin_drive_enable;
		logic       output_invert;
		logic       low_power_select;
		acmp_edge_t event_edge_select;
		logic       positive_input_select;
		acmp_neg_t  negative_input_select;
	} acmp_setup_t;

	// analog core controls of one comparator
	typedef struct packed {
		logic      run;
		logic      low_power;
		logic      pos_sel_ladder;
		acmp_neg_t neg_sel;
	} acmp_core_ctl_t;

endpackage

// >>> core/acmp_edge_unit.sv
`timescale 1ns/1ps
`default_nettype none

// synchroniser, edge tracking and sticky event flag for one comparator
module acmp_edge_unit
	import acmp_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// analog side
	input  wire logic       raw_result,
	// controls
	input  wire logic       running,
	input  wire logic       output_invert,
	input  wire acmp_edge_t edge_sel,
	input  wire logic       clear_event,
	// status
	output logic            sync_result,
	output logic            event_flag
);

	logic        meta_q, meta_d;
	logic        sync_q, sync_d;
	logic        prev_q, prev_d;
	logic        evt_q, evt_d;
	acmp_state_t st_q, st_d;
	logic        pol_res;
	logic        rise, fall, hit;

	// two stage synchroniser; first stage only feeds the second
	always_comb begin
		meta_d = raw_result;
		sync_d = meta_q;
	end

	// polarity applied after sync, so flag and read share one sense
	assign pol_res = running & (sync_q ^ output_invert);

	// edge tracker and event flag
	always_comb begin
		prev_d = pol_res;
		st_d   = st_q;
		evt_d  = evt_q;
		rise   = pol_res & ~prev_q;
		fall   = ~pol_res & prev_q;
		hit    = 1'b0;
		case (st_q)
			ACMP_ST_IDLE: begin
				if (edge_sel != ACMP_EDGE_OFF && running)
					st_d = ACMP_ST_FIRST;
			end
			ACMP_ST_FIRST: begin
				hit = rise | fall; // first event takes either direction
				if (hit)
					st_d = ACMP_ST_ARMED;
			end
			ACMP_ST_ARMED: begin
				case (edge_sel)
					ACMP_EDGE_RISE: hit = rise;
					ACMP_EDGE_FALL: hit = fall;
					ACMP_EDGE_ANY:  hit = rise | fall;
					default:        hit = 1'b0;
				endcase
			end
			default: st_d = ACMP_ST_IDLE;
		endcase
		// edge select zero or comparator off returns to the first-edge rule
		if (edge_sel == ACMP_EDGE_OFF || !running)
			st_d = ACMP_ST_IDLE;
		// a set flag masks further events; hardware never clears it
		if (clear_event)
			evt_d = 1'b0;
		if (hit && !evt_q)
			evt_d = 1'b1; // set wins over a same-cycle clear only if the flag was clear; a set flag is cleared
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			evt_q  <= 1'b0;
			st_q   <= ACMP_ST_IDLE;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			evt_q  <= evt_d;
			st_q   <= st_d;
		end
	end

	assign sync_result = pol_res;
	assign event_flag  = evt_q;

endmodule // acmp_edge_unit

`default_nettype wire

// >>> core/acmp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acmp_cfg.svh"

// Overview of operation
// - enable bit 15 runs the comparator
// - pin-drive bit routes result to pin
// - pin path bypasses the clock synchroniser
// - invert bit flips the result
// - bit 12 selects low-power mode
// - edge select: any, falling, rising, off
// - first event after arming takes any edge
// - event flag bit 9 masks further events
// - bit 4 picks ladder or pin one
// - negative select: bandgap half, pins 4,3,2
// - idle-halt stops all comparators in idle
// - status mirrors event flags at 8, 9
// - status mirrors results at 0, 1
// - one or two instances; absent reads zero
// - unimplemented bits read zero; reset zero
module acmp_top
	import acmp_pkg::*;
#(
	parameter int NUM_CMP = 2
)(
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// device power state
	input  wire logic        idle_mode,
	// analog cores
	input  wire logic [1:0]  core_result,
	output acmp_core_ctl_t   core_ctl1,
	output acmp_core_ctl_t   core_ctl2,
	// result pins
	output logic [1:0]       result_pin,
	output logic [1:0]       result_pin_oe_n
);

	// refuse widths the status layout cannot hold
	initial begin
		if (NUM_CMP < 1 || NUM_CMP > 2)
			$error("acmp_top: NUM_CMP must be 1 or 2");
	end

	acmp_setup_t    setup_q [2];
	acmp_setup_t    setup_d [2];
	logic           idle_halt_q, idle_halt_d;
	logic [31:0]    prdata_q, prdata_d;
	logic           pready_q, pready_d;
	logic           pslverr_q, pslverr_d;
	acmp_core_ctl_t ctl_q [2];
	acmp_core_ctl_t ctl_d [2];
	logic [1:0]     oe_n_q, oe_n_d;
	wire logic [1:0] running;
	wire logic [1:0] sync_res;
	wire logic [1:0] evt;
	logic [1:0]     clr_evt;
	logic           access_ph;
	logic           wr_low, wr_high;

	// pack one setup register image for reads; gaps read zero
	function automatic logic [15:0] setup_image(input acmp_setup_t s, input logic res, input logic ev);
		logic [15:0] v;
		v = 16'h0000;
		v[`ACMP_BIT_ENABLE]                    = s.enable;
		v[`ACMP_BIT_PIN_DRIVE]                 = s.pin_drive_enable;
		v[`ACMP_BIT_INVERT]                    = s.output_invert;
		v[`ACMP_BIT_LOW_POWER]                 = s.low_power_select;
		v[`ACMP_BIT_EVENT]                     = ev;
		v[`ACMP_BIT_RESULT]                    = res;
		v[`ACMP_BIT_EDGE_HI:`ACMP_BIT_EDGE_LO] = s.event_edge_select;
		v[`ACMP_BIT_POS_SEL]                   = s.positive_input_select;
		v[`ACMP_BIT_NEG_HI:`ACMP_BIT_NEG_LO]   = s.negative_input_select;
		return v;
	endfunction

	// unpack a write into setup fields, honouring byte strobes
	function automatic acmp_setup_t setup_write(input acmp_setup_t s, input logic [15:0] w,
		input logic lo, input logic hi);
		acmp_setup_t n;
		n = s;
		if (hi) begin
			n.enable           = w[`ACMP_BIT_ENABLE];
			n.pin_drive_enable = w[`ACMP_BIT_PIN_DRIVE];
			n.output_invert    = w[`ACMP_BIT_INVERT];
			n.low_power_select = w[`ACMP_BIT_LOW_POWER];
		end
		if (lo) begin
			n.event_edge_select     = acmp_edge_t'(w[`ACMP_BIT_EDGE_HI:`ACMP_BIT_EDGE_LO]);
			n.positive_input_select = w[`ACMP_BIT_POS_SEL];
			n.negative_input_select = acmp_neg_t'(w[`ACMP_BIT_NEG_HI:`ACMP_BIT_NEG_LO]);
		end
		return n;
	endfunction

	// one access cycle per transfer: answered at the first access edge
	assign access_ph = psel & penable & ~pready_q;
	assign wr_low    = pstrb[0];
	assign wr_high   = pstrb[1];

	// per-comparator run gating, core controls and edge units
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cmp
			if (gi < NUM_CMP) begin : g_on
				// enabled and not halted by idle
				assign running[gi] = setup_q[gi].enable & ~(idle_halt_q & idle_mode);
				acmp_edge_unit u_edge (
					.pclk          (pclk),
					.presetn       (presetn),
					.raw_result    (core_result[gi]),
					.running       (running[gi]),
					.output_invert (setup_q[gi].output_invert),
					.edge_sel      (setup_q[gi].event_edge_select),
					.clear_event   (clr_evt[gi]),
					.sync_result   (sync_res[gi]),
					.event_flag    (evt[gi])
				);
			end else begin : g_off
				// absent instance reads as zero
				assign running[gi]  = 1'b0;
				assign sync_res[gi] = 1'b0;
				assign evt[gi]      = 1'b0;
			end
		end
	endgenerate

	// event flag clear: write of zero to bit 9 of a setup register
	always_comb begin
		clr_evt = 2'b00;
		if (access_ph && pwrite && wr_high) begin
			if (paddr == `ACMP_OFF_SETUP1)
				clr_evt[0] = ~pwdata[`ACMP_BIT_EVENT];
			else if (paddr == `ACMP_OFF_SETUP2)
				clr_evt[1] = ~pwdata[`ACMP_BIT_EVENT];
		end
	end

	// register writes, read mux and bus answer
	always_comb begin
		setup_d[0]  = setup_q[0];
		setup_d[1]  = setup_q[1];
		idle_halt_d = idle_halt_q;
		prdata_d    = prdata_q;
		pready_d    = access_ph;
		pslverr_d   = 1'b0;
		if (access_ph) begin
			prdata_d = 32'h0000_0000;
			if (paddr == `ACMP_OFF_SETUP1) begin
				if (pwrite)
					setup_d[0] = setup_write(setup_q[0], pwdata[15:0], wr_low, wr_high);
				else
					prdata_d[15:0] = setup_image(setup_q[0], sync_res[0], evt[0]);
			end else if (paddr == `ACMP_OFF_SETUP2 && NUM_CMP > 1) begin
				if (pwrite)
					setup_d[1] = setup_write(setup_q[1], pwdata[15:0], wr_low, wr_high);
				else
					prdata_d[15:0] = setup_image(setup_q[1], sync_res[1], evt[1]);
			end else if (paddr == `ACMP_OFF_STATUS) begin
				if (pwrite && wr_high)
					idle_halt_d = pwdata[`ACMP_BIT_IDLE_HALT];
				else if (!pwrite) begin
					prdata_d[`ACMP_BIT_IDLE_HALT] = idle_halt_q;
					prdata_d[`ACMP_BIT_EVT_MIRROR+:2] = evt;
					prdata_d[`ACMP_BIT_RES_MIRROR+:2] = sync_res;
				end
			end else begin
				pslverr_d = 1'b1; // unmapped address
			end
		end
	end

	// core controls and pin enables, each registered
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ctl_d[i].run            = running[i];
			ctl_d[i].low_power      = setup_q[i].low_power_select;
			ctl_d[i].pos_sel_ladder = setup_q[i].positive_input_select;
			ctl_d[i].neg_sel        = setup_q[i].negative_input_select;
			oe_n_d[i] = ~(setup_q[i].pin_drive_enable & running[i]);
		end
	end

	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_q[0]  <= acmp_setup_t'($bits(acmp_setup_t)'(`ACMP_SETUP_RESET));
			setup_q[1]  <= acmp_setup_t'($bits(acmp_setup_t)'(`ACMP_SETUP_RESET));
			idle_halt_q <= 1'b0;
			prdata_q    <= 32'h0000_0000;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			ctl_q[0]    <= '0;
			ctl_q[1]    <= '0;
			oe_n_q      <= 2'h3;
		end else begin
			setup_q[0]  <= setup_d[0];
			setup_q[1]  <= setup_d[1];
			idle_halt_q <= idle_halt_d;
			prdata_q    <= prdata_d;
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
			ctl_q[0]    <= ctl_d[0];
			ctl_q[1]    <= ctl_d[1];
			oe_n_q      <= oe_n_d;
		end
	end

	// pin data carries the analog result xor output_invert, unsynchronised on purpose
	// limitation: it is not a flip-flop output; the pad needs no clock here
	always_comb begin
		for (int i = 0; i < 2; i++)
			result_pin[i] = (i < NUM_CMP) ? (core_result[i] ^ setup_q[i].output_invert) : 1'b0;
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign core_ctl1       = ctl_q[0];
	assign core_ctl2       = ctl_q[1];
	assign result_pin_oe_n = oe_n_q;

endmodule // acmp_top

`default_nettype wire

// >>> bench/acmp_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// bus and routing relations seen from the top ports only
module acmp_top_asserts
	import acmp_pkg::*;
#(
	parameter int NUM_CMP = 2
)(
	// apb
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [11:0]    paddr,
	input wire logic [31:0]    pwdata,
	input wire logic [3:0]     pstrb,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	// analog side
	input wire logic [1:0]     core_result,
	input wire acmp_core_ctl_t core_ctl1,
	input wire logic [1:0]     result_pin
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// decode helpers; setup2 is absent on single-comparator builds
	wire logic mapped = paddr == 12'h000 || paddr == 12'h008 || (paddr == 12'h004 && NUM_CMP == 2);
	wire logic wr_s1  = psel && penable && pwrite && !pready && paddr == 12'h000;
	chk_pready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
	chk_access_answer: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half set");
	chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read data");
	chk_unmapped_err: assert property (pready && !mapped |-> pslverr) else $error("unmapped accepted");
	chk_mapped_ok: assert property (pready && mapped |-> !pslverr) else $error("mapped refused");
	chk_disable_run: assert property (wr_s1 && pstrb[1] && !pwdata[15] |=> ##1 !core_ctl1.run)
		else $error("core runs while disabled");
	chk_input_route: assert property (wr_s1 && pstrb[0] |=> ##1
		{core_ctl1.pos_sel_ladder, core_ctl1.neg_sel} == $past({pwdata[4], pwdata[1:0]}, 2))
		else $error("input route wrong");
	// with the bus quiet the invert setting cannot move, so pin xor core stays put
	chk_pin_direct: assert property ($stable(psel) && !psel |-> $stable(result_pin ^ core_result))
		else $error("pin not direct");
endmodule // acmp_top_asserts
bind acmp_top acmp_top_asserts #(.NUM_CMP(NUM_CMP)) acmp_top_asserts_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .core_result, .core_ctl1, .result_pin);
`default_nettype wire

// >>> bench/acmp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural analog core: bench sets the outcome per negative route
module acmp_core_model
	import acmp_pkg::*;
(
	// controls from the block
	input wire acmp_core_ctl_t ctl,
	// plus-above-minus outcome for each negative route
	input wire logic [3:0]     gt,
	// raw comparator output
	output logic               res
);
	// a stopped core shows no settled level, so give the opposite one
	always_comb res = ctl.run ? gt[ctl.neg_sel] : ~gt[ctl.neg_sel];
endmodule // acmp_core_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top
	import acmp_pkg::*;
;
	logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle_mode = 0, er;
	logic [11:0]    paddr = 0;
	logic [31:0]    pwdata = 0, prdata, rd;
	wire logic [1:0] core_result, result_pin, result_pin_oe_n;
	logic [3:0]     gt1 = 0, gt2 = 0;
	logic           pready, pslverr;
	acmp_core_ctl_t core_ctl1, core_ctl2;
	int             n_errors = 0, compares = 0;
	always #12.5 pclk = ~pclk;
	acmp_top #(.NUM_CMP(2)) acmp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .prdata, .pready, .pslverr, .idle_mode, .core_result, .core_ctl1, .core_ctl2,
		.result_pin, .result_pin_oe_n);
	acmp_core_model cm1_i (.ctl(core_ctl1), .gt(gt1), .res(core_result[0]));
	acmp_core_model cm2_i (.ctl(core_ctl2), .gt(gt2), .res(core_result[1]));
	// one apb transfer; request held until the rising edge that samples pready high
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		rd = prdata; er = pslverr;
		if (n >= 50) n_errors++;
		psel <= 0; penable <= 0;
	endtask
	task rchk(input logic [11:0] a, input logic [15:0] e, input logic ee);
		apb(0, a, 16'h0000);
		`CHK("prdata", {16'h0000, e}, rd)
		`CHK("pslverr", ee, er)
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task t_reset;
		rchk(12'h000, 16'h0000, 0);
		rchk(12'h004, 16'h0000, 0);
		rchk(12'h008, 16'h0000, 0);
		rchk(12'h00c, 16'h0000, 1);
	endtask
	task t_fields;
		apb(1, 12'h000, 16'hf013);
		cyc(6);
		rchk(12'h000, 16'hf113, 0);
		rchk(12'h008, 16'h0001, 0);
		`CHK("oe_n", 1'b0, result_pin_oe_n[0])
		`CHK("pin", 1'b1, result_pin[0])
		`CHK("low_power", 1'b1, core_ctl1.low_power)
		`CHK("ladder", 1'b1, core_ctl1.pos_sel_ladder)
		`CHK("neg", ACMP_NEG_BGAP, core_ctl1.neg_sel)
		apb(1, 12'h000, 16'h3013);
		cyc(4);
		`CHK("run", 1'b0, core_ctl1.run)
		`CHK("oe_n", 1'b1, result_pin_oe_n[0])
		rchk(12'h000, 16'h3013, 0);
		apb(1, 12'h004, 16'h1011);
		rchk(12'h004, 16'h1011, 0);
	endtask
	// first event takes a rising edge under every select, the later falling one follows the select
	task t_event(input logic [1:0] e);
		logic [15:0] s;
		s = 16'h8000 | {8'h00, e, 6'h00};
		gt1 <= 4'h0;
		apb(1, 12'h000, 16'h8000);
		cyc(6);
		apb(1, 12'h000, s);
		gt1 <= 4'h1;
		cyc(6);
		rchk(12'h000, s | 16'h0300, 0);
		rchk(12'h008, 16'h0101, 0);
		apb(1, 12'h000, s);
		rchk(12'h000, s | 16'h0100, 0);
		gt1 <= 4'h0;
		cyc(6);
		rchk(12'h000, e == 2'h1 ? s : s | 16'h0200, 0);
	endtask
	task t_idle;
		apb(1, 12'h000, 16'h8000);
		idle_mode <= 1;
		cyc(4);
		`CHK("run", 1'b1, core_ctl1.run)
		apb(1, 12'h008, 16'h8000);
		cyc(4);
		`CHK("run", 1'b0, core_ctl1.run)
		rchk(12'h008, 16'h8000, 0);
		idle_mode <= 0;
		cyc(4);
		`CHK("run", 1'b1, core_ctl1.run)
	endtask
	task stop_test;
		$display("n_errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		cyc(16);
		presetn <= 1;
		t_reset;
		t_fields;
		for (int e = 1; e < 4; e++) t_event(e[1:0]);
		t_idle;
		stop_test;
	end
	// the sequence needs well under a thousand transfers
	initial begin
		cyc(20000);
		n_errors++;
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
